// file: hw/opc_regs.sv
// AXI4-Lite register bank steering the codec output path enables and pop suppression.
//
// Added by the designer: register access over AXI4-Lite.
`timescale 1ns/1ps
module opc_regs (
    // Clock and reset.
    input wire logic clk_sys,
    input wire logic reset,
    // AXI4-Lite write address and data.
    input wire logic [11:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // AXI4-Lite write response.
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read.
    input wire logic [11:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Analog control status from the rails.
    input wire logic mid_rail_reference,
    input wire logic master_bias_on,
    // Path controls.
    output logic dac_oversample_select,
    output logic left_out_mixer_on,
    output logic right_out_mixer_on,
    output logic left_phones_amp_on,
    output logic right_phones_amp_on,
    output logic left_line_amp_on,
    output logic right_line_amp_on,
    output logic left_spk_mixer_on,
    output logic right_spk_mixer_on,
    output logic left_spk_out_on,
    output logic right_spk_out_on,
    // Headphone pop suppression.
    output logic left_phones_unshort,
    output logic right_phones_unshort,
    output logic left_phones_final_stage,
    output logic right_phones_final_stage,
    output logic left_phones_mid_stage,
    output logic right_phones_mid_stage,
    output logic left_phones_first_stage,
    output logic right_phones_first_stage,
    output logic left_phones_shorted,
    output logic right_phones_shorted,
    // Line pop suppression.
    output logic left_line_unshort,
    output logic right_line_unshort,
    output logic left_line_final_stage,
    output logic right_line_final_stage,
    output logic left_line_mid_stage,
    output logic right_line_mid_stage,
    output logic left_line_first_stage,
    output logic right_line_first_stage,
    output logic left_line_shorted,
    output logic right_line_shorted
);
    // Maps a byte address onto a one-hot register select.
    function automatic opc_pkg::opc_sel_t decode(input logic [11:0] addr);
        case (addr)
            opc_pkg::OFF_OUT_MIXER: decode = opc_pkg::SEL_OUT_MIXER;
            opc_pkg::OFF_PHONES_AMP: decode = opc_pkg::SEL_PHONES_AMP;
            opc_pkg::OFF_LINE_AMP: decode = opc_pkg::SEL_LINE_AMP;
            opc_pkg::OFF_SPK_MIXER: decode = opc_pkg::SEL_SPK_MIXER;
            opc_pkg::OFF_SPK_OUT: decode = opc_pkg::SEL_SPK_OUT;
            opc_pkg::OFF_DAC_DIGITAL: decode = opc_pkg::SEL_DAC_DIGITAL;
            opc_pkg::OFF_PHONES_POP: decode = opc_pkg::SEL_PHONES_POP;
            opc_pkg::OFF_LINE_POP: decode = opc_pkg::SEL_LINE_POP;
            default: decode = opc_pkg::SEL_NONE;
        endcase
    endfunction : decode

    logic aw_held_ff;
    logic [11:0] awaddr_ff;
    logic w_held_ff;
    logic [31:0] wdata_ff;
    logic [3:0] wstrb_ff;
    logic bvalid_ff;
    logic [1:0] bresp_ff;
    logic rvalid_ff;
    logic [31:0] rdata_ff;
    logic [1:0] rresp_ff;
    logic [1:0] out_mixer_ff;
    logic [1:0] phones_amp_ff;
    logic [1:0] line_amp_ff;
    logic [1:0] spk_mixer_ff;
    logic [1:0] spk_out_ff;
    logic osr_ff;
    logic do_write;
    opc_pkg::opc_sel_t wr_sel;
    opc_pkg::opc_sel_t rd_sel;
    logic [7:0] phones_pop;
    logic [7:0] line_pop;
    logic [31:0] nxt_rdata;
    logic lane0_write;
    logic wr_unmapped;
    logic status_hit;
    logic rd_unmapped;

    // Address and data are each held once taken; the write commits when both are present.
    assign s_axi_awready = ~aw_held_ff & ~bvalid_ff;
    assign s_axi_wready = ~w_held_ff & ~bvalid_ff;
    assign do_write = aw_held_ff & w_held_ff & ~bvalid_ff;
    assign lane0_write = do_write & wstrb_ff[0];
    assign wr_sel = decode(awaddr_ff);
    assign rd_sel = decode(s_axi_araddr);
    assign wr_unmapped = (wr_sel == opc_pkg::SEL_NONE);
    assign status_hit = (s_axi_araddr == opc_pkg::OFF_STATUS);
    assign rd_unmapped = (rd_sel == opc_pkg::SEL_NONE) & ~status_hit;

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            aw_held_ff <= 1'h0;
        end else if (s_axi_awvalid && s_axi_awready) begin
            aw_held_ff <= 1'h1;
        end else if (do_write) begin
            aw_held_ff <= 1'h0;
        end
    end

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            awaddr_ff <= 12'h000;
        end else if (s_axi_awvalid && s_axi_awready) begin
            awaddr_ff <= s_axi_awaddr;
        end
    end

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            w_held_ff <= 1'h0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            w_held_ff <= 1'h1;
        end else if (do_write) begin
            w_held_ff <= 1'h0;
        end
    end

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            wdata_ff <= 32'h00000000;
            wstrb_ff <= 4'h0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            wdata_ff <= s_axi_wdata;
            wstrb_ff <= s_axi_wstrb;
        end
    end

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            bvalid_ff <= 1'h0;
        end else if (do_write) begin
            bvalid_ff <= 1'h1;
        end else if (s_axi_bready) begin
            bvalid_ff <= 1'h0;
        end
    end

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            bresp_ff <= opc_pkg::RESP_OKAY;
        end else if (do_write) begin
            bresp_ff <= wr_unmapped ? opc_pkg::RESP_SLVERR : opc_pkg::RESP_OKAY;
        end
    end

    // Each register takes only byte lane 0; a cleared strobe bit leaves it untouched.
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            out_mixer_ff <= opc_pkg::RST_PAIR;
        end else if (lane0_write && (wr_sel == opc_pkg::SEL_OUT_MIXER)) begin
            out_mixer_ff <= wdata_ff[1:0];
        end
    end

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            phones_amp_ff <= opc_pkg::RST_PAIR;
        end else if (lane0_write && (wr_sel == opc_pkg::SEL_PHONES_AMP)) begin
            phones_amp_ff <= wdata_ff[1:0];
        end
    end

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            line_amp_ff <= opc_pkg::RST_PAIR;
        end else if (lane0_write && (wr_sel == opc_pkg::SEL_LINE_AMP)) begin
            line_amp_ff <= wdata_ff[1:0];
        end
    end

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            spk_mixer_ff <= opc_pkg::RST_PAIR;
        end else if (lane0_write && (wr_sel == opc_pkg::SEL_SPK_MIXER)) begin
            spk_mixer_ff <= wdata_ff[1:0];
        end
    end

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            spk_out_ff <= opc_pkg::RST_PAIR;
        end else if (lane0_write && (wr_sel == opc_pkg::SEL_SPK_OUT)) begin
            spk_out_ff <= wdata_ff[1:0];
        end
    end

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            osr_ff <= opc_pkg::RST_OSR;
        end else if (lane0_write && (wr_sel == opc_pkg::SEL_DAC_DIGITAL)) begin
            osr_ff <= wdata_ff[opc_pkg::BIT_OSR];
        end
    end

    opc_pop_path u_phones_pop (
        .clk_sys(clk_sys),
        .reset(reset),
        .wr_en(do_write && (wr_sel == opc_pkg::SEL_PHONES_POP)),
        .wr_data(wdata_ff[7:0]),
        .wr_strb(wstrb_ff),
        .pop_bits(phones_pop),
        .left_shorted(left_phones_shorted),
        .right_shorted(right_phones_shorted)
    );

    opc_pop_path u_line_pop (
        .clk_sys(clk_sys),
        .reset(reset),
        .wr_en(do_write && (wr_sel == opc_pkg::SEL_LINE_POP)),
        .wr_data(wdata_ff[7:0]),
        .wr_strb(wstrb_ff),
        .pop_bits(line_pop),
        .left_shorted(left_line_shorted),
        .right_shorted(right_line_shorted)
    );

    // Read mux; the status word shows the reference and bias inputs the host must raise first.
    always_comb begin
        nxt_rdata = 32'h00000000;
        case (rd_sel)
            opc_pkg::SEL_OUT_MIXER: nxt_rdata[1:0] = out_mixer_ff;
            opc_pkg::SEL_PHONES_AMP: nxt_rdata[1:0] = phones_amp_ff;
            opc_pkg::SEL_LINE_AMP: nxt_rdata[1:0] = line_amp_ff;
            opc_pkg::SEL_SPK_MIXER: nxt_rdata[1:0] = spk_mixer_ff;
            opc_pkg::SEL_SPK_OUT: nxt_rdata[1:0] = spk_out_ff;
            opc_pkg::SEL_DAC_DIGITAL: nxt_rdata[opc_pkg::BIT_OSR] = osr_ff;
            opc_pkg::SEL_PHONES_POP: nxt_rdata[7:0] = phones_pop;
            opc_pkg::SEL_LINE_POP: nxt_rdata[7:0] = line_pop;
            default: begin
                if (s_axi_araddr == opc_pkg::OFF_STATUS) begin
                    nxt_rdata[1:0] = {master_bias_on, mid_rail_reference};
                end
            end
        endcase
    end

    assign s_axi_arready = ~rvalid_ff;

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            rvalid_ff <= 1'h0;
        end else if (s_axi_arvalid && s_axi_arready) begin
            rvalid_ff <= 1'h1;
        end else if (s_axi_rready) begin
            rvalid_ff <= 1'h0;
        end
    end

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            rdata_ff <= 32'h00000000;
            rresp_ff <= opc_pkg::RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            rdata_ff <= nxt_rdata;
            rresp_ff <= rd_unmapped ? opc_pkg::RESP_SLVERR : opc_pkg::RESP_OKAY;
        end
    end

    assign s_axi_bvalid = bvalid_ff;
    assign s_axi_bresp = bresp_ff;
    assign s_axi_rvalid = rvalid_ff;
    assign s_axi_rdata = rdata_ff;
    assign s_axi_rresp = rresp_ff;

    assign dac_oversample_select = osr_ff;
    assign left_out_mixer_on = out_mixer_ff[opc_pkg::BIT_LEFT];
    assign right_out_mixer_on = out_mixer_ff[opc_pkg::BIT_RIGHT];
    assign left_phones_amp_on = phones_amp_ff[opc_pkg::BIT_LEFT];
    assign right_phones_amp_on = phones_amp_ff[opc_pkg::BIT_RIGHT];
    assign left_line_amp_on = line_amp_ff[opc_pkg::BIT_LEFT];
    assign right_line_amp_on = line_amp_ff[opc_pkg::BIT_RIGHT];
    assign left_spk_mixer_on = spk_mixer_ff[opc_pkg::BIT_LEFT];
    assign right_spk_mixer_on = spk_mixer_ff[opc_pkg::BIT_RIGHT];
    assign left_spk_out_on = spk_out_ff[opc_pkg::BIT_LEFT];
    assign right_spk_out_on = spk_out_ff[opc_pkg::BIT_RIGHT];

    assign left_phones_unshort = phones_pop[opc_pkg::BIT_L_UNSHORT];
    assign right_phones_unshort = phones_pop[opc_pkg::BIT_R_UNSHORT];
    assign left_phones_final_stage = phones_pop[opc_pkg::BIT_L_FINAL];
    assign right_phones_final_stage = phones_pop[opc_pkg::BIT_R_FINAL];
    assign left_phones_mid_stage = phones_pop[opc_pkg::BIT_L_MID];
    assign right_phones_mid_stage = phones_pop[opc_pkg::BIT_R_MID];
    assign left_phones_first_stage = phones_pop[opc_pkg::BIT_L_FIRST];
    assign right_phones_first_stage = phones_pop[opc_pkg::BIT_R_FIRST];
    assign left_line_unshort = line_pop[opc_pkg::BIT_L_UNSHORT];
    assign right_line_unshort = line_pop[opc_pkg::BIT_R_UNSHORT];
    assign left_line_final_stage = line_pop[opc_pkg::BIT_L_FINAL];
    assign right_line_final_stage = line_pop[opc_pkg::BIT_R_FINAL];
    assign left_line_mid_stage = line_pop[opc_pkg::BIT_L_MID];
    assign right_line_mid_stage = line_pop[opc_pkg::BIT_R_MID];
    assign left_line_first_stage = line_pop[opc_pkg::BIT_L_FIRST];
    assign right_line_first_stage = line_pop[opc_pkg::BIT_R_FIRST];
endmodule : opc_regs

// file: common/opc_pkg.sv
// Package with register map, field positions and reset values for the output path control block.
package opc_pkg;
    localparam logic [11:0] OFF_OUT_MIXER = 12'h034;
    localparam logic [11:0] OFF_PHONES_AMP = 12'h038;
    localparam logic [11:0] OFF_LINE_AMP = 12'h03C;
    localparam logic [11:0] OFF_SPK_MIXER = 12'h040;
    localparam logic [11:0] OFF_SPK_OUT = 12'h044;
    localparam logic [11:0] OFF_DAC_DIGITAL = 12'h084;
    localparam logic [11:0] OFF_PHONES_POP = 12'h168;
    localparam logic [11:0] OFF_LINE_POP = 12'h178;
    localparam logic [11:0] OFF_STATUS = 12'h200;
    localparam logic [7:0] IDX_OUT_MIXER = 8'h0D;
    localparam logic [7:0] IDX_PHONES_AMP = 8'h0E;
    localparam logic [7:0] IDX_LINE_AMP = 8'h0F;
    localparam logic [7:0] IDX_SPK_MIXER = 8'h10;
    localparam logic [7:0] IDX_SPK_OUT = 8'h11;
    localparam logic [7:0] IDX_DAC_DIGITAL = 8'h21;
    localparam logic [7:0] IDX_PHONES_POP = 8'h5A;
    localparam logic [7:0] IDX_LINE_POP = 8'h5E;
    localparam int BIT_LEFT = 1;
    localparam int BIT_RIGHT = 0;
    localparam int BIT_OSR = 0;
    localparam int BIT_L_UNSHORT = 7;
    localparam int BIT_L_FINAL = 6;
    localparam int BIT_L_MID = 5;
    localparam int BIT_L_FIRST = 4;
    localparam int BIT_R_UNSHORT = 3;
    localparam int BIT_R_FINAL = 2;
    localparam int BIT_R_MID = 1;
    localparam int BIT_R_FIRST = 0;
    localparam logic [1:0] RST_PAIR = 2'h0;
    localparam logic RST_OSR = 1'h0;
    localparam logic [7:0] RST_POP = 8'h00;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    typedef enum logic [7:0] {
        SEL_NONE = 8'h00,
        SEL_OUT_MIXER = 8'h01,
        SEL_PHONES_AMP = 8'h02,
        SEL_LINE_AMP = 8'h04,
        SEL_SPK_MIXER = 8'h08,
        SEL_SPK_OUT = 8'h10,
        SEL_DAC_DIGITAL = 8'h20,
        SEL_PHONES_POP = 8'h40,
        SEL_LINE_POP = 8'h80
    } opc_sel_t;
endpackage : opc_pkg

// file: hw/opc_pop_path.sv
// One headphone or line output pair: pop-suppression stage bits and the resulting ground shorts.
`timescale 1ns/1ps
module opc_pop_path (
    // Clock and reset.
    input wire logic clk_sys,
    input wire logic reset,
    // Register write.
    input wire logic wr_en,
    input wire logic [7:0] wr_data,
    input wire logic [3:0] wr_strb,
    // Stage controls.
    output logic [7:0] pop_bits,
    output logic left_shorted,
    output logic right_shorted
);
    logic [7:0] pop_ff;

    // Only byte lane 0 holds the eight stage bits.
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            pop_ff <= opc_pkg::RST_POP;
        end else if (wr_en && wr_strb[0]) begin
            pop_ff <= wr_data;
        end
    end

    assign pop_bits = pop_ff;
    assign left_shorted = ~pop_ff[opc_pkg::BIT_L_UNSHORT];
    assign right_shorted = ~pop_ff[opc_pkg::BIT_R_UNSHORT];
endmodule : opc_pop_path

// file: sim/opc_regs_asserts.sv
// Checker for bus timing and path control outputs of the output path register bank.
`timescale 1ns/1ps
module opc_regs_asserts (
    // Clock, reset and bus.
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [31:0] s_axi_rdata,
    // Path controls.
    input wire logic dac_oversample_select,
    input wire logic right_spk_out_on,
    input wire logic left_phones_unshort,
    input wire logic right_phones_unshort,
    input wire logic left_line_unshort,
    input wire logic right_line_unshort,
    input wire logic left_phones_shorted,
    input wire logic right_phones_shorted,
    input wire logic left_line_shorted,
    input wire logic right_line_shorted
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (reset);
    AST_PH_SHORT: assert property (
        {left_phones_shorted, right_phones_shorted} == ~{left_phones_unshort, right_phones_unshort})
        else $error("headphone short does not follow its control bit");
    AST_LN_SHORT: assert property (
        {left_line_shorted, right_line_shorted} == ~{left_line_unshort, right_line_unshort})
        else $error("line short does not follow its control bit");
    AST_RST_STATE: assert property (
        $fell(reset) |-> &{left_phones_shorted, right_phones_shorted, left_line_shorted, right_line_shorted}
        && !dac_oversample_select && !right_spk_out_on) else $error("path state wrong after reset");
    AST_OSR_HOLD: assert property (
        !$rose(s_axi_bvalid) |-> $stable(dac_oversample_select)) else $error("oversample bit moved without a write");
    AST_POP_HOLD: assert property (
        !$rose(s_axi_bvalid) |-> $stable({left_phones_unshort, left_line_unshort}))
        else $error("short control moved without a write");
    AST_WR_LAT: assert property (
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
        else $error("write response late");
    AST_RD_LAT: assert property (
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("read data late");
    AST_RD_HOLD: assert property (
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data not held");
endmodule : opc_regs_asserts

// file: sim/opc_regs_tb.sv
// Self-checking bench for the output path register bank.
`timescale 1ns/1ps
module opc_regs_tb;
    logic clk_sys = 1'h0, reset = 1'h1, mid_rail_reference = 1'h0, master_bias_on = 1'h0;
    logic [11:0] s_axi_awaddr = 12'h0, s_axi_araddr = 12'h0;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
    logic [3:0] s_axi_wstrb = 4'h0;
    logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0, s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic dac_oversample_select, left_out_mixer_on, right_out_mixer_on, left_phones_amp_on, right_phones_amp_on;
    logic left_line_amp_on, right_line_amp_on, left_spk_mixer_on, right_spk_mixer_on, left_spk_out_on;
    logic right_spk_out_on, left_phones_unshort, right_phones_unshort, left_phones_final_stage;
    logic right_phones_final_stage, left_phones_mid_stage, right_phones_mid_stage, left_phones_first_stage;
    logic right_phones_first_stage, left_phones_shorted, right_phones_shorted, left_line_unshort, right_line_unshort;
    logic left_line_final_stage, right_line_final_stage, left_line_mid_stage, right_line_mid_stage;
    logic left_line_first_stage, right_line_first_stage, left_line_shorted, right_line_shorted;
    logic [1:0] bq [$];
    logic [33:0] rq [$];
    logic [7:0] mir [8] = '{default: 8'h0};
    logic [7:0] msk [8] = '{8'h03, 8'h03, 8'h03, 8'h03, 8'h03, 8'h01, 8'hFF, 8'hFF};
    logic [7:0] seq [8] = '{8'h11, 8'h33, 8'h77, 8'hF7, 8'hFF, 8'h7F, 8'h77, 8'h00};
    logic [11:0] adr [8] = '{opc_pkg::OFF_OUT_MIXER, opc_pkg::OFF_PHONES_AMP, opc_pkg::OFF_LINE_AMP,
        opc_pkg::OFF_SPK_MIXER, opc_pkg::OFF_SPK_OUT, opc_pkg::OFF_DAC_DIGITAL, opc_pkg::OFF_PHONES_POP,
        opc_pkg::OFF_LINE_POP};
    int failures = 0, n_checks = 0, cyc = 0;
    wire [30:0] outs = {dac_oversample_select, left_out_mixer_on, right_out_mixer_on, left_phones_amp_on,
        right_phones_amp_on, left_line_amp_on, right_line_amp_on, left_spk_mixer_on, right_spk_mixer_on,
        left_spk_out_on, right_spk_out_on, left_phones_unshort, left_phones_final_stage, left_phones_mid_stage,
        left_phones_first_stage, right_phones_unshort, right_phones_final_stage, right_phones_mid_stage,
        right_phones_first_stage, left_line_unshort, left_line_final_stage, left_line_mid_stage,
        left_line_first_stage, right_line_unshort, right_line_final_stage, right_line_mid_stage,
        right_line_first_stage, left_phones_shorted, right_phones_shorted, left_line_shorted, right_line_shorted};

    opc_regs dut_u (.*);

    always #10 clk_sys = ~clk_sys;

    task automatic check(input logic [33:0] seen, input logic [33:0] exp);
        n_checks++;
        if (seen !== exp) begin
            failures++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    task automatic stop_test();
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : stop_test

    // Address and data are offered together; bready stays up until the response.
    task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s, input logic [1:0] er);
        bit aw = 1'h1, w = 1'h1, b = 1'h1;
        @(posedge clk_sys);
        bq.push_back(er);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_wstrb <= s;
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        s_axi_bready <= 1'h1;
        while (b) begin
            @(posedge clk_sys);
            if (aw && s_axi_awready) begin
                aw = 1'h0;
                s_axi_awvalid <= 1'h0;
            end
            if (w && s_axi_wready) begin
                w = 1'h0;
                s_axi_wvalid <= 1'h0;
            end
            if (s_axi_bvalid) begin
                b = 1'h0;
                s_axi_bready <= 1'h0;
            end
        end
    endtask : wr

    // The read data is left waiting one cycle before rready rises.
    task automatic rd(input logic [11:0] a, input logic [33:0] exp);
        bit ar = 1'h1, r = 1'h1, rr = 1'h0;
        @(posedge clk_sys);
        rq.push_back(exp);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'h1;
        while (r) begin
            @(posedge clk_sys);
            if (ar && s_axi_arready) begin
                ar = 1'h0;
                s_axi_arvalid <= 1'h0;
            end
            if (s_axi_rvalid && rr) begin
                r = 1'h0;
                s_axi_rready <= 1'h0;
            end else if (s_axi_rvalid) begin
                rr = 1'h1;
                s_axi_rready <= 1'h1;
            end
        end
    endtask : rd

    task automatic chk_out();
        #1;
        check({3'h0, outs}, {3'h0, mir[5][0], mir[0][1:0], mir[1][1:0], mir[2][1:0], mir[3][1:0],
            mir[4][1:0], mir[6], mir[7], ~mir[6][7], ~mir[6][3], ~mir[7][7], ~mir[7][3]});
    endtask : chk_out

    task automatic wreg(input int i, input logic [31:0] d);
        mir[i] = d[7:0] & msk[i];
        wr(adr[i], d, 4'hF, opc_pkg::RESP_OKAY);
        chk_out();
        rd(adr[i], {opc_pkg::RESP_OKAY, 24'h0, mir[i]});
    endtask : wreg

    always @(posedge clk_sys) begin
        if (s_axi_bvalid && s_axi_bready) check({32'h0, s_axi_bresp}, {32'h0, bq.pop_front()});
        if (s_axi_rvalid && s_axi_rready) check({s_axi_rresp, s_axi_rdata}, rq.pop_front());
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            failures++;
            stop_test();
        end
    end

    initial begin
        void'($urandom(24));
        repeat (20) @(posedge clk_sys);
        reset <= 1'h0;
        mid_rail_reference <= 1'h1;
        master_bias_on <= 1'h1;
        chk_out();
        for (int i = 0; i < 8; i++) rd(adr[i], {opc_pkg::RESP_OKAY, 32'h0});
        for (int v = 0; v < 4; v++) begin
            for (int i = 0; i < 5; i++) wreg(i, ($urandom() & 32'hFFFF_FFFC) | 32'(v));
        end
        wreg(5, 32'h1);
        wreg(5, 32'hFFFF_FFFE);
        for (int p = 6; p < 8; p++) begin
            foreach (seq[k]) begin
                wreg(p, {$urandom() & 32'hFFFF_FF00} | {24'h0, seq[k]});
                if (k == 0) repeat (1000) @(posedge clk_sys);
            end
        end
        wr(adr[6], 32'hFF, 4'h0, opc_pkg::RESP_OKAY);
        chk_out();
        wr(12'h100, 32'hFF, 4'hF, opc_pkg::RESP_SLVERR);
        rd(12'h100, {opc_pkg::RESP_SLVERR, 32'h0});
        mid_rail_reference <= 1'($urandom());
        master_bias_on <= 1'($urandom());
        @(posedge clk_sys);
        rd(opc_pkg::OFF_STATUS, {opc_pkg::RESP_OKAY, 30'h0, master_bias_on, mid_rail_reference});
        wr(opc_pkg::OFF_STATUS, 32'h3, 4'hF, opc_pkg::RESP_SLVERR);
        wreg(6, 32'hFF);
        wreg(0, 32'h3);
        @(posedge clk_sys);
        reset <= 1'h1;
        repeat (3) @(posedge clk_sys);
        reset <= 1'h0;
        foreach (mir[i]) mir[i] = 8'h0;
        chk_out();
        repeat (2) @(posedge clk_sys);
        stop_test();
    end
endmodule : opc_regs_tb

bind opc_regs opc_regs_asserts chk_u (.*);
